// ### rtl/tscm_pkg.sv
// Shared constants for the timeslot channel monitor.
package tscm_pkg;
  // Register indices; the byte address on the bus is four times these.
  localparam logic [5:0] IDX_COMMON_CONTROL_THREE = 6'h14;
  localparam logic [5:0] IDX_COMMON_CONTROL_FOUR  = 6'h15;
  localparam logic [5:0] IDX_TRANSMIT_SLOT_SNOOP  = 6'h22;
  localparam logic [5:0] IDX_RECEIVE_SLOT_SNOOP   = 6'h2a;
  // Bus, register and select widths.
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam int         REG_W      = 8;
  localparam int         SEL_W      = 5;
  // Field positions inside the two control registers.
  localparam int         SEL_LSB    = 0;
  localparam int         SEL_MSB    = 4;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SNOOP_RESET = 8'h00;
  // Frame geometry: 32 slots of 8 bits, 256 bits in one 125 us frame.
  localparam int         POS_W      = 8;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  // PRBS single-slot mode code.
  localparam logic [1:0] PRBS_SINGLE_SLOT = 2'h1;
endpackage : tscm_pkg

// ### rtl/tscm_snoop.sv
`timescale 1ns/1ps
// Captures the octet of one selected timeslot from a serial bit stream.
module tscm_snoop (
  input  wire logic       ref_clk,    // System clock.
  input  wire logic       srst,       // Synchronous reset, active high.
  input  wire logic       bit_stb,    // One-cycle strobe per line bit.
  input  wire logic       bit_data,   // Line bit, valid with bit_stb.
  input  wire logic       frame_sync, // With bit_stb: first bit of frame.
  input  wire logic [4:0] slot_sel,   // Selected timeslot number.
  output logic      [7:0] octet,      // Last complete selected octet.
  output logic            slot_hit    // Current bit is in selected slot.
);

  logic [7:0] pos_reg;     // Bits seen since the frame started.
  logic [7:0] pos_next;    // Next bit position.
  logic       sync_reg;    // A frame start has been seen.
  logic       sync_next;   // Next value of sync_reg.
  logic [7:0] shift_reg;   // Partial octet, first bit shifts to the top.
  logic [7:0] shift_next;  // Next partial octet.
  logic [7:0] octet_reg;   // Held complete octet.
  logic [7:0] octet_next;  // Next held octet.
  logic [7:0] cur_pos;     // Position of the bit on the strobe now.
  logic       load;        // Last bit of the selected slot arrives.

  // A frame marker restarts the count at bit zero.
  assign cur_pos  = frame_sync ? 8'h00 : pos_reg;
  assign slot_hit = (sync_reg | frame_sync)
                    & (cur_pos[7:3] == slot_sel);
  assign load     = bit_stb & slot_hit
                    & (cur_pos[2:0] == tscm_pkg::LAST_BIT);
  assign octet    = octet_reg;

  // Next state: count bits, shift the slot in, publish whole octets.
  always_comb begin
    pos_next   = pos_reg;
    sync_next  = sync_reg | (bit_stb & frame_sync);
    shift_next = shift_reg;
    octet_next = octet_reg;
    if (bit_stb) begin
      // The count wraps from 255 to 0 at the end of the frame.
      pos_next = cur_pos + 8'h01;
    end
    if (bit_stb && slot_hit) begin
      // First bit ends in bit 7, last bit in bit 0.
      shift_next = {shift_reg[6:0], bit_data};
    end
    if (load) begin
      // Only a whole octet is published, never a partial one.
      octet_next = {shift_reg[6:0], bit_data};
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pos_reg   <= 8'h00;
      sync_reg  <= 1'b0;
      shift_reg <= 8'h00;
      octet_reg <= tscm_pkg::SNOOP_RESET;
    end else begin
      pos_reg   <= pos_next;
      sync_reg  <= sync_next;
      shift_reg <= shift_next;
      octet_reg <= octet_next;
    end
  end

  // The held octet changes only when a complete slot has arrived.
  property p_octet_whole;
    @(posedge ref_clk) disable iff (srst)
      !load |=> $stable(octet_reg);
  endproperty
  a_octet_whole: assert property (p_octet_whole)
    else $error("Snoop octet changed without a complete slot.");

  // The last bit of the slot lands in bit 0 of the octet.
  property p_last_bit_low;
    @(posedge ref_clk) disable iff (srst)
      load |=> (octet_reg[0] == $past(bit_data));
  endproperty
  a_last_bit_low: assert property (p_last_bit_low)
    else $error("Last slot bit not in bit 0 of octet.");

endmodule : tscm_snoop

// ### rtl/tscm_top.sv
`timescale 1ns/1ps
module tscm_top (
  input  wire logic        ref_clk,        // System clock, 100 MHz.
  input  wire logic        srst,           // Sync reset, active high.
  input  wire logic        psel,           // APB select.
  input  wire logic        penable,        // APB access phase.
  input  wire logic        pwrite,         // APB write when high.
  input  wire logic [7:0]  paddr,          // APB byte address.
  input  wire logic [31:0] pwdata,         // APB write data.
  output logic      [31:0] prdata,         // APB read data.
  output logic             pready,         // APB ready.
  output logic             pslverr,        // APB error.
  input  wire logic        tx_bit_stb,     // Transmit bit strobe.
  input  wire logic        tx_bit_data,    // Transmit line bit.
  input  wire logic        tx_frame_sync,  // Transmit frame first bit.
  input  wire logic        rx_bit_stb,     // Receive bit strobe.
  input  wire logic        rx_bit_data,    // Receive line bit.
  input  wire logic        rx_frame_sync,  // Receive frame first bit.
  input  wire logic [1:0]  tx_prbs_mode,   // Transmit PRBS mode.
  input  wire logic [1:0]  rx_prbs_mode,   // Receive PRBS mode.
  output logic             tx_prbs_slot,   // Transmit PRBS slot active.
  output logic             rx_prbs_slot    // Receive PRBS slot active.
);

  logic [7:0]  ctrl3_reg;    // Common control three.
  logic [7:0]  ctrl3_next;   // Next value of control three.
  logic [7:0]  ctrl4_reg;    // Common control four.
  logic [7:0]  ctrl4_next;   // Next value of control four.
  logic [31:0] rdata_reg;    // Read data held for the access phase.
  logic [31:0] rdata_next;   // Next read data.
  logic        err_reg;      // Error answer held for the access phase.
  logic        err_next;     // Next error answer.
  logic [4:0]  tx_sel;       // Transmit slot select field.
  logic [4:0]  rx_sel;       // Receive slot select field.
  logic [7:0]  tx_octet;     // Captured transmit octet.
  logic [7:0]  rx_octet;     // Captured receive octet.
  logic        tx_hit;       // Transmit bit is in the selected slot.
  logic        rx_hit;       // Receive bit is in the selected slot.
  logic [5:0]  idx;          // Word index of the bus address.
  logic        setup;        // APB setup cycle.
  logic        wr_fire;      // APB write completes this edge.

  assign idx     = paddr[7:2];
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = psel & penable & err_reg;

  // Bit 4 is the MSB and bit 0 the LSB of each slot number.
  assign tx_sel =
    ctrl3_reg[tscm_pkg::SEL_MSB:tscm_pkg::SEL_LSB];
  assign rx_sel =
    ctrl4_reg[tscm_pkg::SEL_MSB:tscm_pkg::SEL_LSB];

  // Transmit and receive capture run independently of each other.
  tscm_snoop u_tx_snoop (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .bit_stb    (tx_bit_stb),
    .bit_data   (tx_bit_data),
    .frame_sync (tx_frame_sync),
    .slot_sel   (tx_sel),
    .octet      (tx_octet),
    .slot_hit   (tx_hit)
  );

  tscm_snoop u_rx_snoop (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .bit_stb    (rx_bit_stb),
    .bit_data   (rx_bit_data),
    .frame_sync (rx_frame_sync),
    .slot_sel   (rx_sel),
    .octet      (rx_octet),
    .slot_hit   (rx_hit)
  );

  // In single-slot PRBS mode the same selects mark the PRBS slot.
  assign tx_prbs_slot = (tx_prbs_mode == tscm_pkg::PRBS_SINGLE_SLOT)
                        & tx_hit;
  assign rx_prbs_slot = (rx_prbs_mode == tscm_pkg::PRBS_SINGLE_SLOT)
                        & rx_hit;

  // Next state of the register file and of the read answer.
  always_comb begin
    ctrl3_next = ctrl3_reg;
    ctrl4_next = ctrl4_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      // Decode in the setup cycle so the answer comes from flip-flops.
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      unique case (idx)
        tscm_pkg::IDX_COMMON_CONTROL_THREE: begin
          rdata_next = {24'h00_0000, ctrl3_reg};
        end
        tscm_pkg::IDX_COMMON_CONTROL_FOUR: begin
          rdata_next = {24'h00_0000, ctrl4_reg};
        end
        tscm_pkg::IDX_TRANSMIT_SLOT_SNOOP: begin
          rdata_next = {24'h00_0000, tx_octet};
          err_next   = pwrite;
        end
        tscm_pkg::IDX_RECEIVE_SLOT_SNOOP: begin
          rdata_next = {24'h00_0000, rx_octet};
          err_next   = pwrite;
        end
        default: begin
          // Unmapped words read zero and answer with an error.
          err_next = 1'b1;
        end
      endcase
    end
    if (wr_fire) begin
      // Only the two control words take writes; snoop words ignore them.
      if (idx == tscm_pkg::IDX_COMMON_CONTROL_THREE) begin
        ctrl3_next = pwdata[7:0];
      end
      if (idx == tscm_pkg::IDX_COMMON_CONTROL_FOUR) begin
        ctrl4_next = pwdata[7:0];
      end
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl3_reg <= tscm_pkg::CTRL_RESET;
      ctrl4_reg <= tscm_pkg::CTRL_RESET;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      ctrl3_reg <= ctrl3_next;
      ctrl4_reg <= ctrl4_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // A write to control three moves the transmit select.
  property p_tx_sel_write;
    @(posedge ref_clk) disable iff (srst)
      (wr_fire && idx == tscm_pkg::IDX_COMMON_CONTROL_THREE)
        |=> (tx_sel == $past(pwdata[4:0]));
  endproperty
  a_tx_sel_write: assert property (p_tx_sel_write)
    else $error("Transmit select did not take the written value.");

  // A write to control four moves the receive select.
  property p_rx_sel_write;
    @(posedge ref_clk) disable iff (srst)
      (wr_fire && idx == tscm_pkg::IDX_COMMON_CONTROL_FOUR)
        |=> (rx_sel == $past(pwdata[4:0]));
  endproperty
  a_rx_sel_write: assert property (p_rx_sel_write)
    else $error("Receive select did not take the written value.");

  // A write to a snoop word leaves both selects alone.
  property p_snoop_ro;
    @(posedge ref_clk) disable iff (srst)
      (wr_fire && (idx == tscm_pkg::IDX_TRANSMIT_SLOT_SNOOP
                   || idx == tscm_pkg::IDX_RECEIVE_SLOT_SNOOP))
        |=> ($stable(ctrl3_reg) && $stable(ctrl4_reg) && $past(pslverr));
  endproperty
  a_snoop_ro: assert property (p_snoop_ro)
    else $error("Write to snoop word had an effect.");

  // Reading the transmit snoop word returns the captured octet.
  property p_tx_read;
    @(posedge ref_clk) disable iff (srst)
      (setup && idx == tscm_pkg::IDX_TRANSMIT_SLOT_SNOOP)
        |=> (prdata == {24'h00_0000, $past(tx_octet)});
  endproperty
  a_tx_read: assert property (p_tx_read)
    else $error("Transmit snoop read returned wrong data.");

  // Reading the receive snoop word returns the captured octet.
  property p_rx_read;
    @(posedge ref_clk) disable iff (srst)
      (setup && idx == tscm_pkg::IDX_RECEIVE_SLOT_SNOOP)
        |=> (prdata == {24'h00_0000, $past(rx_octet)});
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("Receive snoop read returned wrong data.");

  // The PRBS slot marks appear only in single-slot mode.
  property p_prbs_slot;
    @(posedge ref_clk) disable iff (srst)
      (tx_prbs_slot || rx_prbs_slot)
        |-> ((tx_prbs_slot && tx_prbs_mode == 2'h1 && tx_hit)
             || (rx_prbs_slot && rx_prbs_mode == 2'h1 && rx_hit));
  endproperty
  a_prbs_slot: assert property (p_prbs_slot)
    else $error("PRBS slot mark outside single-slot mode.");

  // Reading control three returns the stored word with zero top bits.
  property p_ctrl3_read;
    @(posedge ref_clk) disable iff (srst)
      (setup && idx == tscm_pkg::IDX_COMMON_CONTROL_THREE)
        |=> (prdata == {24'h00_0000, $past(ctrl3_reg)});
  endproperty
  a_ctrl3_read: assert property (p_ctrl3_read)
    else $error("Control three read returned wrong data.");

  // Reading control four returns the stored word with zero top bits.
  property p_ctrl4_read;
    @(posedge ref_clk) disable iff (srst)
      (setup && idx == tscm_pkg::IDX_COMMON_CONTROL_FOUR)
        |=> (prdata == {24'h00_0000, $past(ctrl4_reg)});
  endproperty
  a_ctrl4_read: assert property (p_ctrl4_read)
    else $error("Control four read returned wrong data.");

  // Without a bus write the transmit select holds, so no slot drift.
  property p_tx_sel_hold;
    @(posedge ref_clk) disable iff (srst)
      !wr_fire |=> $stable(tx_sel);
  endproperty
  a_tx_sel_hold: assert property (p_tx_sel_hold)
    else $error("Transmit select moved without a write.");

  // Without a bus write the receive select holds, so no slot drift.
  property p_rx_sel_hold;
    @(posedge ref_clk) disable iff (srst)
      !wr_fire |=> $stable(rx_sel);
  endproperty
  a_rx_sel_hold: assert property (p_rx_sel_hold)
    else $error("Receive select moved without a write.");

  // A read of the transmit snoop word is never refused.
  property p_tx_rd_ok;
    @(posedge ref_clk) disable iff (srst)
      (setup && !pwrite && idx == tscm_pkg::IDX_TRANSMIT_SLOT_SNOOP)
        |=> !pslverr;
  endproperty
  a_tx_rd_ok: assert property (p_tx_rd_ok)
    else $error("Transmit snoop read answered with an error.");

  // A read of the receive snoop word is never refused.
  property p_rx_rd_ok;
    @(posedge ref_clk) disable iff (srst)
      (setup && !pwrite && idx == tscm_pkg::IDX_RECEIVE_SLOT_SNOOP)
        |=> !pslverr;
  endproperty
  a_rx_rd_ok: assert property (p_rx_rd_ok)
    else $error("Receive snoop read answered with an error.");

  // A write aimed at a snoop word is flagged, so software sees the slip.
  property p_snoop_wr_err;
    @(posedge ref_clk) disable iff (srst)
      (setup && pwrite && (idx == tscm_pkg::IDX_TRANSMIT_SLOT_SNOOP
                           || idx == tscm_pkg::IDX_RECEIVE_SLOT_SNOOP))
        |=> err_reg;
  endproperty
  a_snoop_wr_err: assert property (p_snoop_wr_err)
    else $error("Write to snoop word was not flagged.");

  // Outside single-slot mode the transmit PRBS slot mark stays low.
  property p_tx_prbs_off;
    @(posedge ref_clk) disable iff (srst)
      (tx_prbs_mode != tscm_pkg::PRBS_SINGLE_SLOT) |-> !tx_prbs_slot;
  endproperty
  a_tx_prbs_off: assert property (p_tx_prbs_off)
    else $error("Transmit PRBS slot mark outside single-slot mode.");

  // Outside single-slot mode the receive PRBS slot mark stays low.
  property p_rx_prbs_off;
    @(posedge ref_clk) disable iff (srst)
      (rx_prbs_mode != tscm_pkg::PRBS_SINGLE_SLOT) |-> !rx_prbs_slot;
  endproperty
  a_rx_prbs_off: assert property (p_rx_prbs_off)
    else $error("Receive PRBS slot mark outside single-slot mode.");

  // In single-slot mode the selected transmit slot carries the mark.
  property p_tx_prbs_on;
    @(posedge ref_clk) disable iff (srst)
      (tx_prbs_mode == tscm_pkg::PRBS_SINGLE_SLOT && tx_hit)
        |-> tx_prbs_slot;
  endproperty
  a_tx_prbs_on: assert property (p_tx_prbs_on)
    else $error("Transmit PRBS slot mark missing in selected slot.");

  // In single-slot mode the selected receive slot carries the mark.
  property p_rx_prbs_on;
    @(posedge ref_clk) disable iff (srst)
      (rx_prbs_mode == tscm_pkg::PRBS_SINGLE_SLOT && rx_hit)
        |-> rx_prbs_slot;
  endproperty
  a_rx_prbs_on: assert property (p_rx_prbs_on)
    else $error("Receive PRBS slot mark missing in selected slot.");

  // The transmit octet moves only on a transmit bit, never on receive.
  property p_tx_indep;
    @(posedge ref_clk) disable iff (srst)
      !tx_bit_stb |=> $stable(tx_octet);
  endproperty
  a_tx_indep: assert property (p_tx_indep)
    else $error("Transmit octet changed without a transmit bit.");

  // The receive octet moves only on a receive bit, never on transmit.
  property p_rx_indep;
    @(posedge ref_clk) disable iff (srst)
      !rx_bit_stb |=> $stable(rx_octet);
  endproperty
  a_rx_indep: assert property (p_rx_indep)
    else $error("Receive octet changed without a receive bit.");

endmodule : tscm_top

// ### tb/tscm_framer_model.sv
`timescale 1ns/1ps
// Framer datapath stand-in: a 256-bit frame, one octet per slot.
module tscm_framer_model (
  input  wire logic       ref_clk,    // System clock.
  input  wire logic       srst,       // Synchronous reset, active high.
  input  wire logic       run,        // Frames flow while high.
  input  wire logic [1:0] gap,        // Idle cycles between strobes.
  input  wire logic [7:0] salt,       // Varies octets per direction.
  output logic            bit_stb,    // One-cycle bit strobe.
  output logic            bit_data,   // Line bit.
  output logic            frame_sync, // First bit of a frame.
  output logic      [4:0] slot        // Slot of the strobed bit.
);
  logic [7:0] pos_reg;  // Bit position inside the frame.
  logic [1:0] wait_reg; // Remaining idle cycles.
  logic       last_reg; // Last bit sent.
  logic [7:0] oct;      // Octet of the current slot.
  assign oct = {pos_reg[7:3], 3'h5} ^ salt;
  // Between strobes the line shows the inverse, so stale bits never pass.
  assign bit_data = bit_stb ? last_reg : ~last_reg;
  // Sends the octet most significant bit first, slot after slot.
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      pos_reg    <= 8'h00;
      wait_reg   <= 2'h0;
      bit_stb    <= 1'b0;
      frame_sync <= 1'b0;
      slot       <= 5'h00;
      last_reg   <= 1'b0;
    end else if (wait_reg != 2'h0) begin
      wait_reg   <= wait_reg - 2'h1;
      bit_stb    <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      bit_stb    <= 1'b1;
      frame_sync <= (pos_reg == 8'h00);
      slot       <= pos_reg[7:3];
      last_reg   <= oct[~pos_reg[2:0]];
      pos_reg    <= pos_reg + 8'h01;
      wait_reg   <= gap;
    end
  end
endmodule : tscm_framer_model

// ### tb/tb.sv
`timescale 1ns/1ps
// Register-level bench for the timeslot channel monitor.
module tb;
  localparam logic [7:0] A3 = 8'h50; // Control three.
  localparam logic [7:0] A4 = 8'h54; // Control four.
  localparam logic [7:0] AT = 8'h88; // Transmit snoop.
  localparam logic [7:0] AR = 8'ha8; // Receive snoop.
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, ts, td, tf, rs, rd, rf, tp, rp;
  logic [1:0] tm, rm;
  logic [4:0] tsl, rsl;
  logic [4:0] sels [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
  int fails = 0;
  int n_tests = 0;
  tscm_top u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_stb(ts), .tx_bit_data(td), .tx_frame_sync(tf),
    .rx_bit_stb(rs), .rx_bit_data(rd), .rx_frame_sync(rf),
    .tx_prbs_mode(tm), .rx_prbs_mode(rm),
    .tx_prbs_slot(tp), .rx_prbs_slot(rp));
  tscm_framer_model u_tx (.ref_clk(ref_clk), .srst(srst), .run(run),
    .gap(2'h0), .salt(8'h3c), .bit_stb(ts), .bit_data(td),
    .frame_sync(tf), .slot(tsl));
  tscm_framer_model u_rx (.ref_clk(ref_clk), .srst(srst), .run(run),
    .gap(2'h2), .salt(8'ha6), .bit_stb(rs), .bit_data(rd),
    .frame_sync(rf), .slot(rsl));
  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Counts a comparison and reports a mismatch.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // One APB transfer; entered and left just after a rising edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  // Expected octet of a slot, as the framer model sends it.
  function automatic logic [31:0] oct(input logic [4:0] s,
                                      input logic [7:0] k);
    return {24'h0, {s, 3'h5} ^ k};
  endfunction : oct
  // Waits out a number of frames at the slowest strobe rate.
  task frames(input int n);
    repeat (n * 768) @(posedge ref_clk);
  endtask : frames
  // Prints the verdict and stops.
  task end_sim;
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
  // Main sequence.
  initial begin
    {srst, psel, penable, pwrite, run} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h0;
    tm = 2'h0;
    rm = 2'h0;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b0, A3, 32'h0);
    chk("ctrl3 reset", r, {24'h0, tscm_pkg::CTRL_RESET});
    xfer(1'b0, AT, 32'h0);
    chk("tx snoop reset", r, {24'h0, tscm_pkg::SNOOP_RESET});
    xfer(1'b0, 8'h00, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    run <= 1'b1;
    // Each select bit alone, plus both ends of the range.
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, A3, {24'h0, 3'h7, sels[i]});
      xfer(1'b1, A4, {27'h0, ~sels[i]});
      xfer(1'b0, A3, 32'h0);
      chk("ctrl3 back", r, {24'h0, 3'h7, sels[i]});
      xfer(1'b0, A4, 32'h0);
      chk("ctrl4 back", r, {27'h0, ~sels[i]});
      frames(2);
      xfer(1'b0, AT, 32'h0);
      chk("tx snoop", r, oct(sels[i], 8'h3c));
      xfer(1'b0, AR, 32'h0);
      chk("rx snoop", r, oct(~sels[i], 8'ha6));
      chk("rx snoop err", {31'h0, e}, 32'h0);
    end
    xfer(1'b1, AT, 32'hffff_ffff);
    chk("snoop write err", {31'h0, e}, 32'h1);
    xfer(1'b0, AT, 32'h0);
    chk("snoop kept", r, oct(5'h1f, 8'h3c));
    // Every PRBS mode over one frame; only single-slot follows the select.
    for (int m = 0; m < 4; m++) begin
      tm <= m[1:0];
      rm <= m[1:0];
      repeat (768) begin
        @(negedge ref_clk);
        if (ts) chk("tx prbs", {31'h0, tp},
                    {31'h0, m == 1 && tsl == 5'h1f});
        if (rs) chk("rx prbs", {31'h0, rp},
                    {31'h0, m == 1 && rsl == 5'h00});
      end
    end
    // A reset in mid-run clears the receive select and the receive held octet.
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b0, A4, 32'h0);
    chk("ctrl4 reset", r, {24'h0, tscm_pkg::CTRL_RESET});
    xfer(1'b0, AR, 32'h0);
    chk("rx snoop reset", r, {24'h0, tscm_pkg::SNOOP_RESET});
    end_sim();
  end
endmodule : tb
